// >>> core/adcc_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
// start and result handshake between register file and sequencer
interface adcc_conv_if;
   logic             start;
   logic             power_on;
   logic             continuous;
   logic [9:0]       sample;
   logic             done;
   logic             busy;
   logic [9:0]       data;

   modport ctl (output start, power_on, continuous, sample, input done, busy, data);
   modport seq (input start, power_on, continuous, sample, output done, busy, data);
endinterface
`default_nettype wire

// >>> core/adcc_pkg.sv
package adcc_pkg;
   // ***************************************************************
   // register map, byte addresses on the avalon bus
   // ***************************************************************
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFS_STATUS_CTRL = 8'h3C;
   localparam logic [7:0]  OFS_RESULT_HIGH = 8'h40;
   localparam logic [7:0]  OFS_RESULT_LOW  = 8'h44;
   localparam logic [7:0]  OFS_CLOCK_CFG   = 8'h48;

   // ***************************************************************
   // field layout
   // ***************************************************************
   localparam int          BYTE_W          = 8;
   localparam int          RES_W           = 10;
   localparam int          CHAN_W          = 5;
   localparam int          DIV_W           = 3;
   localparam int          MODE_W          = 2;
   localparam int          SCR_DONE_BIT    = 7;
   localparam int          SCR_IEN_BIT     = 6;
   localparam int          SCR_CONT_BIT    = 5;
   localparam int          CLK_DIV_LSB     = 5;
   localparam int          CLK_SRC_BIT     = 4;
   localparam int          CLK_MODE_LSB    = 2;

   // ***************************************************************
   // reset values and codes
   // ***************************************************************
   localparam logic [4:0]  CHAN_POWER_OFF  = 5'h1F;
   localparam logic [4:0]  CHAN_REF_HIGH   = 5'h1D;
   localparam logic [4:0]  CHAN_REF_LOW    = 5'h1E;
   localparam logic [2:0]  DIV_RESET       = 3'h0;
   localparam logic [1:0]  MODE_TRUNC8     = 2'h0;
   localparam logic [1:0]  MODE_RIGHT      = 2'h1;
   localparam logic [1:0]  MODE_LEFT       = 2'h2;
   localparam logic [1:0]  MODE_LEFT_SIGN  = 2'h3;
   localparam logic        SRC_OSC         = 1'b0;

   // ***************************************************************
   // timing: converter clock ticks counted per conversion
   // ***************************************************************
   localparam int          CNT_W           = 5;
   localparam logic [4:0]  CONV_TICKS      = 5'h11;
   localparam int          PRE_W           = 4;
endpackage

// >>> core/adcc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_prescaler (
   input  wire logic                        clk_sys_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        ce_i,
   input  wire logic                        tick_i,
   input  wire logic [adcc_pkg::DIV_W-1:0]  div_i,
   output logic                             tick_o
);
   logic [adcc_pkg::PRE_W-1:0] cnt_r;
   logic [adcc_pkg::PRE_W-1:0] cnt_nxt;
   logic [adcc_pkg::PRE_W-1:0] term;
   logic                       tick_r;
   logic                       tick_nxt;

   // ***************************************************************
   // divide the selected input clock
   // ***************************************************************
   // top code bit set means divide by 16 whatever the low bits
   always_comb begin
      term = div_i[adcc_pkg::DIV_W-1] ? 4'hF : 4'((1 << div_i) - 1);
      tick_nxt = 1'b0;
      cnt_nxt = cnt_r;
      if (tick_i) begin
         if (cnt_r >= term) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (ce_i) begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o = tick_r;

   a_div_one_tick: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && tick_i && div_i == 3'h0) |=> tick_o)
      else $error("divide by one lost an input tick");
endmodule
`default_nettype wire

// >>> core/adcc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_sequencer (
   input  wire logic   clk_sys_i,
   input  wire logic   rst_n_i,
   input  wire logic   ce_i,
   input  wire logic   tick_i,
   adcc_conv_if.seq    conv
);
   typedef enum logic {ADCC_IDLE, ADCC_CONVERT} adcc_seq_e;

   adcc_seq_e                  state_r;
   adcc_seq_e                  state_nxt;
   logic [adcc_pkg::CNT_W-1:0] cnt_r;
   logic [adcc_pkg::CNT_W-1:0] cnt_nxt;
   logic                       done_r;
   logic                       done_nxt;
   logic [adcc_pkg::RES_W-1:0] data_r;
   logic [adcc_pkg::RES_W-1:0] data_nxt;

   // ***************************************************************
   // conversion timing
   // ***************************************************************
   // a start mid-period lands anywhere in a tick, so counting 17 ticks
   // gives between 16 and 17 converter periods
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      data_nxt = data_r;
      if (conv.start) begin
         state_nxt = conv.power_on ? ADCC_CONVERT : ADCC_IDLE;
         cnt_nxt = '0;
      end else begin
         unique case (state_r)
            ADCC_IDLE: begin
            end
            ADCC_CONVERT: begin
               if (tick_i) begin
                  if (cnt_r == adcc_pkg::CONV_TICKS - 5'h1) begin
                     done_nxt = 1'b1;
                     data_nxt = conv.sample;
                     cnt_nxt = '0;
                     // free running only while continuous is set
                     state_nxt = (conv.continuous && conv.power_on) ? ADCC_CONVERT
                                                                   : ADCC_IDLE;
                  end else begin
                     cnt_nxt = cnt_r + 5'h1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_r <= ADCC_IDLE;
         cnt_r <= '0;
         done_r <= 1'b0;
         data_r <= '0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
         data_r <= data_nxt;
      end
   end

   assign conv.done = done_r;
   assign conv.busy = (state_r == ADCC_CONVERT);
   assign conv.data = data_r;

   a_done_tick_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(done_r) |-> $past(cnt_r) == adcc_pkg::CONV_TICKS - 5'h1 && $past(tick_i))
      else $error("conversion ended at the wrong tick count");
endmodule
`default_nettype wire

// >>> core/adcc_top.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
   input  wire logic                          clk_sys_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          ce_i,
   input  wire logic [adcc_pkg::ADDR_W-1:0]   avs_address_i,
   input  wire logic                          avs_read_i,
   input  wire logic                          avs_write_i,
   input  wire logic [31:0]                   avs_writedata_i,
   input  wire logic [3:0]                    avs_byteenable_i,
   output logic [31:0]                        avs_readdata_o,
   output logic                               avs_waitrequest_o,
   input  wire logic                          osc_tick_i,
   input  wire logic [adcc_pkg::RES_W-1:0]    adc_result_i,
   output logic [adcc_pkg::CHAN_W-1:0]        adc_channel_o,
   output logic                               adc_power_on_o,
   output logic                               adc_converting_o,
   output logic                               irq_o
);
   localparam int BW = adcc_pkg::BYTE_W;
   localparam int RW = adcc_pkg::RES_W;

   adcc_conv_if conv ();

   logic                          wait_r;
   logic                          wait_nxt;
   logic [31:0]                   rdata_r;
   logic [31:0]                   rdata_nxt;
   logic                          ien_r;
   logic                          ien_nxt;
   logic                          cont_r;
   logic                          cont_nxt;
   logic [adcc_pkg::CHAN_W-1:0]   chan_r;
   logic [adcc_pkg::CHAN_W-1:0]   chan_nxt;
   logic [adcc_pkg::DIV_W-1:0]    div_r;
   logic [adcc_pkg::DIV_W-1:0]    div_nxt;
   logic                          src_r;
   logic                          src_nxt;
   logic [adcc_pkg::MODE_W-1:0]   mode_r;
   logic [adcc_pkg::MODE_W-1:0]   mode_nxt;
   logic                          pwr_r;
   logic                          pwr_nxt;
   logic                          start_r;
   logic                          start_nxt;
   logic                          warm_r;
   logic                          warm_nxt;
   logic                          flag_r;
   logic                          flag_nxt;
   logic                          irq_r;
   logic                          irq_nxt;
   logic                          lock_r;
   logic                          lock_nxt;
   logic [BW-1:0]                 hi_r;
   logic [BW-1:0]                 hi_nxt;
   logic [BW-1:0]                 lo_r;
   logic [BW-1:0]                 lo_nxt;
   logic [BW-1:0]                 fmt_hi;
   logic [BW-1:0]                 fmt_lo;
   logic [BW-1:0]                 scr_rd;
   logic [BW-1:0]                 clk_rd;
   logic                          wr_take;
   logic                          rd_take;
   logic                          wr_scr;
   logic                          wr_clk;
   logic                          rd_hi;
   logic                          rd_lo;
   logic                          interlock;
   logic                          store;
   logic                          adc_tick;
   logic [RW-1:0]                 d;

   // ***************************************************************
   // converter clock and sequencer
   // ***************************************************************
   adcc_prescaler u_prescaler (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .tick_i    (src_r ? 1'b1 : osc_tick_i),
      .div_i     (div_r),
      .tick_o    (adc_tick)
   );

   adcc_sequencer u_sequencer (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .tick_i    (adc_tick),
      .conv      (conv.seq)
   );

   // settings reach the sequencer one cycle after the write
   assign conv.start      = start_r;
   assign conv.power_on   = pwr_r;
   assign conv.continuous = cont_r;
   assign conv.sample     = adc_result_i;

   // ***************************************************************
   // avalon slave: one wait cycle, then the answer
   // ***************************************************************
   // read effects fire on the cycle readdata is latched so that no
   // event lands between the sample and its clearing
   assign rd_take = avs_read_i && wait_r;
   assign wr_take = avs_write_i && !wait_r && avs_byteenable_i[0];
   assign wr_scr  = wr_take && avs_address_i == adcc_pkg::OFS_STATUS_CTRL;
   assign wr_clk  = wr_take && avs_address_i == adcc_pkg::OFS_CLOCK_CFG;
   assign rd_hi   = rd_take && avs_address_i == adcc_pkg::OFS_RESULT_HIGH;
   assign rd_lo   = rd_take && avs_address_i == adcc_pkg::OFS_RESULT_LOW;

   // readback views, reserved bits zero
   always_comb begin
      scr_rd = '0;
      scr_rd[adcc_pkg::SCR_DONE_BIT] = flag_r && !ien_r;
      scr_rd[adcc_pkg::SCR_IEN_BIT] = ien_r;
      scr_rd[adcc_pkg::SCR_CONT_BIT] = cont_r;
      scr_rd[adcc_pkg::CHAN_W-1:0] = chan_r;
      clk_rd = '0;
      clk_rd[adcc_pkg::CLK_DIV_LSB +: adcc_pkg::DIV_W] = div_r;
      clk_rd[adcc_pkg::CLK_SRC_BIT] = src_r;
      clk_rd[adcc_pkg::CLK_MODE_LSB +: adcc_pkg::MODE_W] = mode_r;
   end

   // bus handshake and read mux; unmapped reads give zero
   always_comb begin
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      if ((avs_read_i || avs_write_i) && wait_r) begin
         wait_nxt = 1'b0;
         rdata_nxt = '0;
         if (avs_read_i) begin
            unique case (avs_address_i)
               adcc_pkg::OFS_STATUS_CTRL: rdata_nxt[BW-1:0] = scr_rd;
               adcc_pkg::OFS_RESULT_HIGH: rdata_nxt[BW-1:0] = hi_r;
               adcc_pkg::OFS_RESULT_LOW:  rdata_nxt[BW-1:0] = lo_r;
               adcc_pkg::OFS_CLOCK_CFG:   rdata_nxt[BW-1:0] = clk_rd;
               default:                   rdata_nxt = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wait_r <= 1'b1;
         rdata_r <= '0;
      end else if (ce_i) begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ***************************************************************
   // result formatting
   // ***************************************************************
   assign d = conv.data;

   always_comb begin
      fmt_hi = '0;
      fmt_lo = '0;
      unique case (mode_r)
         adcc_pkg::MODE_LEFT: begin
            fmt_hi = d[RW-1 -: BW];
            fmt_lo = {d[RW-BW-1:0], 6'h00};
         end
         adcc_pkg::MODE_LEFT_SIGN: begin
            fmt_hi = {~d[RW-1], d[RW-2 -: BW-1]};
            fmt_lo = {d[RW-BW-1:0], 6'h00};
         end
         adcc_pkg::MODE_RIGHT: begin
            fmt_hi = {6'h00, d[RW-1 -: RW-BW]};
            fmt_lo = d[BW-1:0];
         end
         adcc_pkg::MODE_TRUNC8: begin
            fmt_hi = '0;
            fmt_lo = d[RW-1 -: BW];
         end
      endcase
   end

   // ***************************************************************
   // control, status and result registers
   // ***************************************************************
   // channel codes go straight to the analog mux; references and
   // unused codes need no decode here, the mux owns them
   assign interlock = lock_r && mode_r != adcc_pkg::MODE_TRUNC8;
   // a result is dropped while locked, during warm-up, or when a
   // restart is already on its way to the sequencer
   assign store = conv.done && !interlock && !warm_r && !start_r;

   always_comb begin
      ien_nxt = ien_r;
      cont_nxt = cont_r;
      chan_nxt = chan_r;
      div_nxt = div_r;
      src_nxt = src_r;
      mode_nxt = mode_r;
      pwr_nxt = pwr_r;
      start_nxt = wr_scr;
      warm_nxt = warm_r;
      hi_nxt = hi_r;
      lo_nxt = lo_r;
      // the done bit of the written byte is ignored
      if (wr_scr) begin
         ien_nxt = avs_writedata_i[adcc_pkg::SCR_IEN_BIT];
         cont_nxt = avs_writedata_i[adcc_pkg::SCR_CONT_BIT];
         chan_nxt = avs_writedata_i[adcc_pkg::CHAN_W-1:0];
         pwr_nxt = chan_nxt != adcc_pkg::CHAN_POWER_OFF;
         if (pwr_nxt && !pwr_r) begin
            warm_nxt = 1'b1;
         end
      end
      if (wr_clk) begin
         div_nxt = avs_writedata_i[adcc_pkg::CLK_DIV_LSB +: adcc_pkg::DIV_W];
         src_nxt = avs_writedata_i[adcc_pkg::CLK_SRC_BIT];
         mode_nxt = avs_writedata_i[adcc_pkg::CLK_MODE_LSB +: adcc_pkg::MODE_W];
      end
      // the stabilising conversion is consumed without a trace
      if (conv.done && !start_r && warm_r) begin
         warm_nxt = 1'b0;
      end
      if (store) begin
         hi_nxt = fmt_hi;
         lo_nxt = fmt_lo;
      end
   end

   // flags: a set in the same cycle as a clear wins
   always_comb begin
      flag_nxt = flag_r;
      irq_nxt = irq_r;
      lock_nxt = lock_r;
      if (rd_hi || rd_lo) begin
         flag_nxt = 1'b0;
         irq_nxt = 1'b0;
      end
      if (wr_scr) begin
         irq_nxt = 1'b0;
      end
      if (store && !ien_r) begin
         flag_nxt = 1'b1;
      end
      if (store && ien_r) begin
         irq_nxt = 1'b1;
      end
      if (rd_hi && mode_r != adcc_pkg::MODE_TRUNC8) begin
         lock_nxt = 1'b1;
      end
      if (rd_lo) begin
         lock_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ien_r <= 1'b0;
         cont_r <= 1'b0;
         chan_r <= adcc_pkg::CHAN_POWER_OFF;
         div_r <= adcc_pkg::DIV_RESET;
         src_r <= adcc_pkg::SRC_OSC;
         mode_r <= adcc_pkg::MODE_RIGHT;
         pwr_r <= 1'b0;
         start_r <= 1'b0;
         warm_r <= 1'b0;
         flag_r <= 1'b0;
         irq_r <= 1'b0;
         lock_r <= 1'b0;
         hi_r <= '0;
         lo_r <= '0;
      end else if (ce_i) begin
         ien_r <= ien_nxt;
         cont_r <= cont_nxt;
         chan_r <= chan_nxt;
         div_r <= div_nxt;
         src_r <= src_nxt;
         mode_r <= mode_nxt;
         pwr_r <= pwr_nxt;
         start_r <= start_nxt;
         warm_r <= warm_nxt;
         flag_r <= flag_nxt;
         irq_r <= irq_nxt;
         lock_r <= lock_nxt;
         hi_r <= hi_nxt;
         lo_r <= lo_nxt;
      end
   end

   assign avs_readdata_o    = rdata_r;
   assign avs_waitrequest_o = wait_r;
   assign adc_channel_o     = chan_r;
   assign adc_power_on_o    = pwr_r;
   assign adc_converting_o  = conv.busy;
   assign irq_o             = irq_r;

   // ***************************************************************
   // checks
   // ***************************************************************
   a_flag_on_done: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && store && !ien_r) |=> flag_r)
      else $error("done flag not set at conversion end");
   a_flag_never_ien: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(flag_r) |-> $past(!ien_r && store))
      else $error("done flag set while interrupts enabled");
   a_irq_drop_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && wr_scr && !store) |=> !irq_o)
      else $error("interrupt not cleared by control write");
   a_irq_rise_cause: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(irq_o) |-> $past(ien_r && store))
      else $error("interrupt rose without an enabled conversion end");
   a_reset_values: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> chan_r == adcc_pkg::CHAN_POWER_OFF && !ien_r && !cont_r && !flag_r
                   && !adc_power_on_o && mode_r == adcc_pkg::MODE_RIGHT)
      else $error("reset values wrong");
   a_left_layout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && store && mode_r == adcc_pkg::MODE_LEFT)
      |=> hi_r == d[RW-1 -: BW] && lo_r == {d[RW-BW-1:0], 6'h00})
      else $error("left justified layout wrong");
   a_right_layout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && store && mode_r == adcc_pkg::MODE_RIGHT)
      |=> hi_r == {6'h00, d[RW-1 -: RW-BW]} && lo_r == d[BW-1:0])
      else $error("right justified layout wrong");
   a_signed_top_bit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && store && mode_r == adcc_pkg::MODE_LEFT_SIGN)
      |=> hi_r[BW-1] != d[RW-1] && hi_r[BW-2:0] == d[RW-2 -: BW-1])
      else $error("signed layout wrong");
   a_trunc_layout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && store && mode_r == adcc_pkg::MODE_TRUNC8)
      |=> hi_r == '0 && lo_r == d[RW-1 -: BW])
      else $error("truncation layout wrong");
   a_lock_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && conv.done && interlock) |=> $stable(hi_r) && $stable(lo_r) && !$rose(flag_r))
      else $error("result overwritten while interlocked");
   a_write_starts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (ce_i && wr_scr) |=> start_r)
      else $error("control write did not restart conversion");
endmodule
`default_nettype wire

// >>> sim/adcc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog mux: pins, reference nodes, floating when off
module adcc_analog_model (
   input  wire logic       clk_sys_i,
   input  wire logic [4:0] chan_i,
   input  wire logic       pwr_i,
   input  wire logic [9:0] pin_i,
   output logic [9:0]      res_o
);
   initial res_o = 10'h155;
   // unpowered output toggles so a stale value is never trusted
   always @(posedge clk_sys_i) begin
      if (!pwr_i) res_o <= ~res_o;
      else if (chan_i == 5'h1D) res_o <= 10'h3FF;
      else if (chan_i == 5'h1E) res_o <= 10'h000;
      else res_o <= pin_i;
   end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, tk = 1'b0;
   logic        wreq, pwr, irq, busy;
   logic [7:0]  addr = 8'h00, hi, lo;
   logic [31:0] wd = 32'h0, rdat;
   logic [9:0]  res, v, pin = 10'h000;
   logic [4:0]  ch, chan;
   logic [2:0]  c;
   logic [7:0]  expq[$];
   int          comparisons = 0, n_mismatch = 0, cyc = 0, r = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   adcc_top i_adcc_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .osc_tick_i(tk), .adc_result_i(res), .adc_channel_o(chan), .adc_power_on_o(pwr),
      .adc_converting_o(busy), .irq_o(irq));
   adcc_analog_model i_adcc_analog_model (.clk_sys_i(clk_sys_i), .chan_i(chan),
      .pwr_i(pwr), .pin_i(pin), .res_o(res));
   // ****************
   // bus and checks
   // ****************
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one edge passes first, so a release and a new request never share a step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wd <= {24'h0, d};
      rd <= !w;
      wr <= w;
      @(posedge clk_sys_i);
      // only the bench's cycle ceiling ends a wait that never answers
      while (wreq !== 1'b0) begin
         @(posedge clk_sys_i);
      end
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      xfer(1'b0, a, 8'h00);
   endtask
   task automatic wt;
      repeat (30) @(posedge clk_sys_i);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // answer watcher pairs each accepted read with the oldest note
   always @(posedge clk_sys_i) begin
      tk <= 1'($urandom);
      cyc++;
      if (rd && wreq === 1'b0) chk("readdata", expq.pop_front(), rdat[7:0]);
      if (cyc == 3000) begin
         n_mismatch++;
         final_report;
      end
   end
   initial begin
      void'($urandom(32'h1B36));
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd_chk(8'h3C, 8'h1F);
      rd_chk(8'h48, 8'h04);
      xfer(1'b1, 8'h48, 8'h14);
      xfer(1'b1, 8'h3C, 8'h1D);
      wt;
      rd_chk(8'h3C, 8'h1D);
      xfer(1'b1, 8'h3C, 8'h1D);
      wt;
      rd_chk(8'h3C, 8'h9D);
      rd_chk(8'h40, 8'h03);
      rd_chk(8'h44, 8'hFF);
      rd_chk(8'h3C, 8'h1D);
      for (int m = 0; m < 4; m++) begin
         ch = 5'($urandom % 24);
         v = 10'($urandom);
         pin <= v;
         case (m)
            0: begin hi = 8'h00; lo = v[9:2]; end
            1: begin hi = {6'h00, v[9:8]}; lo = v[7:0]; end
            default: begin hi = {v[9] ^ (m == 3), v[8:2]}; lo = {v[1:0], 6'h00}; end
         endcase
         xfer(1'b1, 8'h48, {3'h0, 1'b1, 2'(m), 2'h0});
         xfer(1'b1, 8'h3C, {3'h0, ch});
         wt;
         chk("channel", {3'h0, ch}, {3'h0, chan});
         chk("power", 8'h01, {7'h0, pwr});
         rd_chk(8'h40, hi);
         pin <= ~v;
         xfer(1'b1, 8'h3C, {3'h0, ch});
         wt;
         rd_chk(8'h44, (m == 0) ? ~v[9:2] : lo);
      end
      xfer(1'b1, 8'h3C, {3'h2, ch});
      wt;
      chk("irq", 8'h01, {7'h0, irq});
      rd_chk(8'h3C, {3'h2, ch});
      xfer(1'b1, 8'h3C, {3'h0, ch});
      @(posedge clk_sys_i);
      chk("irq", 8'h00, {7'h0, irq});
      xfer(1'b1, 8'h3C, {3'h1, ch});
      wt;
      rd_chk(8'h3C, {3'h5, ch});
      rd_chk(8'h44, {~v[1:0], 6'h00});
      wt;
      rd_chk(8'h3C, {3'h5, ch});
      // stop the free run; the single conversion after it leaves known data
      xfer(1'b1, 8'h3C, {3'h0, ch});
      wt;
      rd_chk(8'h44, {~v[1:0], 6'h00});
      // slow converter clock, 1.25 MHz then 625 kHz: done must land inside 16 to 17 periods
      for (int k = 0; k < 2; k++) begin
         c = k ? {1'b1, 2'($urandom)} : 3'h3;
         r = k ? 16 : 8;
         xfer(1'b1, 8'h48, {c, 5'h14});
         xfer(1'b1, 8'h3C, {3'h0, ch});
         repeat (16 * r - 8) @(posedge clk_sys_i);
         chk("converting", 8'h01, {7'h0, busy});
         rd_chk(8'h3C, {3'h0, ch});
         repeat (r + 10) @(posedge clk_sys_i);
         chk("converting", 8'h00, {7'h0, busy});
         rd_chk(8'h3C, {3'h4, ch});
         rd_chk(8'h44, ~v[7:0]);
      end
      // a reset after the last conversion must bring back the control, clock and power reset values
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      chk("power", 8'h00, {7'h0, pwr});
      rd_chk(8'h3C, 8'h1F);
      rd_chk(8'h48, 8'h04);
      // let the watcher take the last answer before the verdict
      repeat (2) @(posedge clk_sys_i);
      final_report;
   end
endmodule
`default_nettype wire
